// File: hw/oamu_unit.sv
`timescale 1ns/1ns
// Behaviour
// - Mode 0: register is operand, bytes low
// - Mode 0 issues no bus cycle
// - Mode 1: register is address, unchanged
// - Memory operands are read over the bus
// - Mode 2: advance register after operand fetch
// - Mode 2 step: one byte, two word
// - Mode 2 always two for SP, PC
// - Mode 3: read pointer, then add two
// - Mode 4: decrement, write back, then use
// - Mode 4 step: one byte, two word
// - Mode 4 always two for SP, PC
// - Mode 5: subtract two, read pointer there
// - Mode 6: fetch index word after instruction
// - Mode 6 address is register plus index
// - Specifier: mode bits 5:3, register 2:0
// - Bit 3 set selects deferred variant in modes 1, 3, 5; mode 7 is unsupported
// - Register 7 is PC, 6 is SP
// - Each PC word fetch in modes 2, 3, 6 adds two
module oamu_unit (
    input wire logic CLOCK_IN,                          // 250 MHz clock
    input wire logic RST_N_IN,                          // Async reset, low
    input wire logic REQ_VALID_IN,                      // Decoder offers a specifier
    input wire oamu_pkg::oamu_req_t REQ_IN,             // Specifier and size
    output logic REQ_READY_OUT,                         // Unit idle, takes request
    output logic RES_VALID_OUT,                         // Result pulse
    output oamu_pkg::oamu_res_t RES_OUT,                // Operand result
    output logic BUS_REQ_OUT,                           // Bus read request
    output logic [15:0] BUS_ADDR_OUT,                   // Bus read address
    output logic BUS_BYTE_OUT,                          // Byte-sized operand read
    input wire logic BUS_ACK_IN,                        // Bus read done
    input wire logic [15:0] BUS_RDATA_IN,               // Bus read data
    input wire oamu_pkg::oamu_wr_t RF_WR_IN,            // Execute-stage register write
    output logic RF_WR_BUSY_OUT                         // Execute write refused this cycle
);
    typedef enum logic [2:0] {
        OAMU_IDLE = 3'h0,
        OAMU_RDREG = 3'h1,
        OAMU_IDXF = 3'h3,
        OAMU_PTRF = 3'h2,
        OAMU_OPF = 3'h6,
        OAMU_DONE = 3'h7
    } oamu_state_t;

    oamu_state_t state_reg, state_next;
    logic [2:0] mode_reg, mode_next;
    logic [2:0] sel_reg, sel_next;
    logic byte_reg, byte_next;
    logic [15:0] base_reg, base_next;
    logic [15:0] addr_reg, addr_next;
    logic [15:0] data_reg, data_next;
    logic in_reg_reg, in_reg_next;
    logic unsup_reg, unsup_next;
    logic [15:0] sel_val;
    logic [15:0] pc_val;
    logic [15:0] step;
    logic [2:0] req_mode;
    logic [2:0] req_sel;
    logic deferred;
    oamu_pkg::oamu_wr_t own_wr;
    oamu_pkg::oamu_wr_t rf_wr;

    // Specifier decode
    assign req_mode = REQ_IN.spec[oamu_pkg::SPEC_MODE_HI:oamu_pkg::SPEC_MODE_LO];
    assign req_sel = REQ_IN.spec[oamu_pkg::SPEC_REG_HI:oamu_pkg::SPEC_REG_LO];
    assign deferred = mode_reg[oamu_pkg::SPEC_DEFER_BIT - oamu_pkg::SPEC_MODE_LO];

    oamu_regfile u_regfile (
        .clk_in(CLOCK_IN),
        .rst_n_in(RST_N_IN),
        .rd_a_idx_in(sel_next), // Index of the taking edge, so the read-register cycle sees the new register
        .rd_b_idx_in(oamu_pkg::PC_IDX),
        .wr_in(rf_wr),
        .rd_a_data_out(sel_val),
        .rd_b_data_out(pc_val)
    );

    oamu_step u_step (
        .mode_in(mode_reg),
        .reg_in(sel_reg),
        .byte_op_in(byte_reg),
        .step_out(step)
    );

    // Own register updates win over execute-stage writes
    always_comb begin
        own_wr = '0;
        case (state_reg)
            OAMU_RDREG: begin
                if (mode_reg == oamu_pkg::MODE_AUTODEC || mode_reg == oamu_pkg::MODE_AUTODEC_DEF) begin
                    own_wr.wr_en = 1'b1;
                    own_wr.wr_idx = sel_reg;
                    own_wr.wr_data = sel_val - step;
                end
            end
            OAMU_IDXF: begin
                if (BUS_ACK_IN) begin
                    own_wr.wr_en = 1'b1;
                    own_wr.wr_idx = oamu_pkg::PC_IDX;
                    own_wr.wr_data = base_reg + oamu_pkg::STEP_WORD;
                end
            end
            OAMU_PTRF: begin
                if (BUS_ACK_IN && mode_reg == oamu_pkg::MODE_AUTOINC_DEF) begin
                    own_wr.wr_en = 1'b1;
                    own_wr.wr_idx = sel_reg;
                    own_wr.wr_data = base_reg + step;
                end
            end
            OAMU_OPF: begin
                if (BUS_ACK_IN && mode_reg == oamu_pkg::MODE_AUTOINC) begin
                    own_wr.wr_en = 1'b1;
                    own_wr.wr_idx = sel_reg;
                    own_wr.wr_data = base_reg + step;
                end
            end
            default: begin
                own_wr = '0;
            end
        endcase
        rf_wr = own_wr.wr_en ? own_wr : RF_WR_IN;
        RF_WR_BUSY_OUT = own_wr.wr_en && RF_WR_IN.wr_en;
    end

    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        sel_next = sel_reg;
        byte_next = byte_reg;
        base_next = base_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        in_reg_next = in_reg_reg;
        unsup_next = unsup_reg;
        case (state_reg)
            OAMU_IDLE: begin
                if (REQ_VALID_IN) begin
                    mode_next = req_mode;
                    sel_next = req_sel;
                    byte_next = REQ_IN.byte_op;
                    in_reg_next = 1'b0;
                    unsup_next = 1'b0;
                    addr_next = oamu_pkg::ZERO_WORD;
                    data_next = oamu_pkg::ZERO_WORD;
                    state_next = OAMU_RDREG;
                end
            end
            OAMU_RDREG: begin
                base_next = sel_val;
                case (mode_reg)
                    oamu_pkg::MODE_REG: begin
                        in_reg_next = 1'b1;
                        data_next = byte_reg ? (sel_val & oamu_pkg::LOW_BYTE_MASK) : sel_val;
                        state_next = OAMU_DONE;
                    end
                    oamu_pkg::MODE_REG_DEF, oamu_pkg::MODE_AUTOINC: begin
                        addr_next = sel_val;
                        state_next = OAMU_OPF;
                    end
                    oamu_pkg::MODE_AUTOINC_DEF: begin
                        addr_next = sel_val;
                        state_next = OAMU_PTRF;
                    end
                    oamu_pkg::MODE_AUTODEC, oamu_pkg::MODE_AUTODEC_DEF: begin
                        addr_next = sel_val - step;
                        state_next = deferred ? OAMU_PTRF : OAMU_OPF;
                    end
                    oamu_pkg::MODE_INDEX: begin
                        base_next = pc_val;
                        addr_next = pc_val;
                        state_next = OAMU_IDXF;
                    end
                    default: begin
                        unsup_next = 1'b1;
                        state_next = OAMU_DONE;
                    end
                endcase
            end
            OAMU_IDXF: begin
                if (BUS_ACK_IN) begin
                    // PC as base means the PC already stepped past the index word
                    addr_next = ((sel_reg == oamu_pkg::PC_IDX) ? base_reg + oamu_pkg::STEP_WORD : sel_val)
                        + BUS_RDATA_IN;
                    state_next = OAMU_OPF;
                end
            end
            OAMU_PTRF: begin
                if (BUS_ACK_IN) begin
                    addr_next = BUS_RDATA_IN;
                    state_next = OAMU_OPF;
                end
            end
            OAMU_OPF: begin
                if (BUS_ACK_IN) begin
                    data_next = byte_reg ? (BUS_RDATA_IN & oamu_pkg::LOW_BYTE_MASK) : BUS_RDATA_IN;
                    state_next = OAMU_DONE;
                end
            end
            OAMU_DONE: begin
                state_next = OAMU_IDLE;
            end
            default: begin
                state_next = OAMU_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg <= OAMU_IDLE;
            mode_reg <= oamu_pkg::MODE_REG;
            sel_reg <= 3'h0;
            byte_reg <= 1'b0;
            base_reg <= oamu_pkg::ZERO_WORD;
            addr_reg <= oamu_pkg::ZERO_WORD;
            data_reg <= oamu_pkg::ZERO_WORD;
            in_reg_reg <= 1'b0;
            unsup_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            sel_reg <= sel_next;
            byte_reg <= byte_next;
            base_reg <= base_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            in_reg_reg <= in_reg_next;
            unsup_reg <= unsup_next;
        end
    end

    assign REQ_READY_OUT = (state_reg == OAMU_IDLE);
    assign RES_VALID_OUT = (state_reg == OAMU_DONE);
    assign BUS_REQ_OUT = (state_reg == OAMU_IDXF) || (state_reg == OAMU_PTRF) || (state_reg == OAMU_OPF);
    assign BUS_ADDR_OUT = addr_reg;
    assign BUS_BYTE_OUT = byte_reg && (state_reg == OAMU_OPF);
    assign RES_OUT.in_reg = in_reg_reg;
    assign RES_OUT.reg_num = sel_reg;
    assign RES_OUT.addr = addr_reg;
    assign RES_OUT.data = data_reg;
    assign RES_OUT.unsupported = unsup_reg;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence seq_index_taken;
        state_reg == OAMU_IDXF && BUS_ACK_IN;
    endsequence

    sequence seq_pointer_taken;
        state_reg == OAMU_PTRF && BUS_ACK_IN;
    endsequence

    chk_mode0_no_bus: assert property (
        (state_reg == OAMU_RDREG && mode_reg == oamu_pkg::MODE_REG)
        |=> (state_reg == OAMU_DONE && !BUS_REQ_OUT && RES_OUT.in_reg))
        else $error("mode 0 did not answer from the register");

    chk_byte_low_half: assert property (
        (RES_VALID_OUT && RES_OUT.in_reg && byte_reg) |-> (RES_OUT.data[15:8] == 8'h00))
        else $error("byte register operand has high byte set");

    chk_register_kept: assert property (
        (state_reg != OAMU_IDLE && (mode_reg == oamu_pkg::MODE_REG || mode_reg == oamu_pkg::MODE_REG_DEF))
        |-> !own_wr.wr_en)
        else $error("register written in mode 0 or 1");

    chk_deferred_addr: assert property (
        (state_reg == OAMU_RDREG && mode_reg == oamu_pkg::MODE_REG_DEF)
        |=> (BUS_REQ_OUT && BUS_ADDR_OUT == $past(sel_val)))
        else $error("mode 1 address is not the register value");

    chk_postinc_step: assert property (
        (state_reg == OAMU_OPF && BUS_ACK_IN && mode_reg == oamu_pkg::MODE_AUTOINC)
        |-> (own_wr.wr_en && own_wr.wr_idx == sel_reg && own_wr.wr_data == base_reg
            + ((byte_reg && sel_reg < oamu_pkg::SP_IDX) ? oamu_pkg::STEP_BYTE : oamu_pkg::STEP_WORD)))
        else $error("post-increment amount wrong");

    chk_predec_use: assert property (
        (state_reg == OAMU_RDREG && mode_reg == oamu_pkg::MODE_AUTODEC)
        |-> own_wr.wr_en ##1 (BUS_REQ_OUT && BUS_ADDR_OUT == $past(sel_val) - ((byte_reg && sel_reg < oamu_pkg::SP_IDX)
            ? oamu_pkg::STEP_BYTE : oamu_pkg::STEP_WORD)))
        else $error("pre-decrement address wrong");

    chk_ptr_redirect: assert property (
        seq_pointer_taken |=> (state_reg == OAMU_OPF && BUS_ADDR_OUT == $past(BUS_RDATA_IN)))
        else $error("pointer word not used as operand address");

    chk_pc_advance: assert property (
        seq_index_taken |-> (own_wr.wr_en && own_wr.wr_idx == oamu_pkg::PC_IDX
            && own_wr.wr_data == BUS_ADDR_OUT + oamu_pkg::STEP_WORD))
        else $error("program counter not advanced by two");

    chk_index_sum: assert property (
        (seq_index_taken and (sel_reg != oamu_pkg::PC_IDX))
        |=> (BUS_ADDR_OUT == $past(sel_val) + $past(BUS_RDATA_IN)))
        else $error("index address is not register plus index");

    chk_result_bound: assert property (
        (state_reg == OAMU_OPF && BUS_ACK_IN) |=> RES_VALID_OUT ##1 REQ_READY_OUT)
        else $error("operand fetch did not complete");

endmodule // oamu_unit

// File: hw/oamu_pkg.sv
package oamu_pkg;

    localparam int WORD_W = 16;
    localparam int REG_IDX_W = 3;
    localparam int MODE_W = 3;
    localparam int SPEC_W = 6;
    localparam int NUM_REGS = 8;

    // Operand specifier field positions
    localparam int SPEC_MODE_HI = 5;
    localparam int SPEC_MODE_LO = 3;
    localparam int SPEC_REG_HI = 2;
    localparam int SPEC_REG_LO = 0;
    localparam int SPEC_DEFER_BIT = 3;

    // Addressing modes
    localparam logic [2:0] MODE_REG = 3'h0;
    localparam logic [2:0] MODE_REG_DEF = 3'h1;
    localparam logic [2:0] MODE_AUTOINC = 3'h2;
    localparam logic [2:0] MODE_AUTOINC_DEF = 3'h3;
    localparam logic [2:0] MODE_AUTODEC = 3'h4;
    localparam logic [2:0] MODE_AUTODEC_DEF = 3'h5;
    localparam logic [2:0] MODE_INDEX = 3'h6;

    // Stack pointer and program counter register numbers
    localparam logic [2:0] SP_IDX = 3'h6;
    localparam logic [2:0] PC_IDX = 3'h7;

    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [15:0] LOW_BYTE_MASK = 16'h00ff;

    typedef struct packed {
        logic [SPEC_W-1:0] spec;   // Mode in [5:3], register in [2:0]
        logic byte_op;             // Byte-sized instruction
    } oamu_req_t;

    typedef struct packed {
        logic in_reg;              // Operand lives in a general register
        logic [REG_IDX_W-1:0] reg_num;
        logic [WORD_W-1:0] addr;   // Effective address for memory operands
        logic [WORD_W-1:0] data;   // Operand value
        logic unsupported;         // Mode outside this unit
    } oamu_res_t;

    typedef struct packed {
        logic wr_en;
        logic [REG_IDX_W-1:0] wr_idx;
        logic [WORD_W-1:0] wr_data;
    } oamu_wr_t;

endpackage

// File: hw/oamu_regfile.sv
`timescale 1ns/1ns
module oamu_regfile #(
    parameter int WIDTH = oamu_pkg::WORD_W,
    parameter int DEPTH = oamu_pkg::NUM_REGS,
    parameter int IDX_W = oamu_pkg::REG_IDX_W
) (
    input wire logic clk_in,                // Clock
    input wire logic rst_n_in,              // Async reset, low
    input wire logic [IDX_W-1:0] rd_a_idx_in, // Read port A index
    input wire logic [IDX_W-1:0] rd_b_idx_in, // Read port B index
    input wire oamu_pkg::oamu_wr_t wr_in,   // Write port
    output logic [WIDTH-1:0] rd_a_data_out, // Registered read A
    output logic [WIDTH-1:0] rd_b_data_out  // Registered read B
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] rd_a_next;
    logic [WIDTH-1:0] rd_b_next;

    always_comb begin
        rd_a_next = mem_reg[rd_a_idx_in];
        rd_b_next = mem_reg[rd_b_idx_in];
        // Write-through, so a write on the read edge is not lost to the reader
        if (wr_in.wr_en && wr_in.wr_idx == rd_a_idx_in) begin
            rd_a_next = wr_in.wr_data;
        end
        if (wr_in.wr_en && wr_in.wr_idx == rd_b_idx_in) begin
            rd_b_next = wr_in.wr_data;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_a_data_out <= '0;
            rd_b_data_out <= '0;
        end else begin
            rd_a_data_out <= rd_a_next;
            rd_b_data_out <= rd_b_next;
        end
    end

    // Storage has no reset, as in a real register file
    always_ff @(posedge clk_in) begin
        if (wr_in.wr_en) begin
            mem_reg[wr_in.wr_idx] <= wr_in.wr_data;
        end
    end
endmodule // oamu_regfile

// File: hw/oamu_step.sv
`timescale 1ns/1ns
module oamu_step (
    input wire logic [2:0] mode_in,         // Addressing mode
    input wire logic [2:0] reg_in,          // Selected register
    input wire logic byte_op_in,            // Byte-sized instruction
    output logic [15:0] step_out            // Register step amount
);
    always_comb begin
        step_out = oamu_pkg::STEP_WORD;
        if ((mode_in == oamu_pkg::MODE_AUTOINC || mode_in == oamu_pkg::MODE_AUTODEC) && byte_op_in
            && reg_in != oamu_pkg::SP_IDX && reg_in != oamu_pkg::PC_IDX) begin
            step_out = oamu_pkg::STEP_BYTE;
        end
    end
endmodule // oamu_step

// File: bench/oamu_bus_model.sv
`timescale 1ns/1ns
module oamu_bus_model (
    input wire logic clk_in,             // Clock
    input wire logic rst_n_in,           // Async reset, low
    input wire logic bus_req_in,         // Read request from unit
    input wire logic [15:0] bus_addr_in, // Read address
    input wire logic [2:0] wait_in,      // Wait cycles before each ack
    output logic ack_out,                // Read done pulse
    output logic [15:0] rdata_out        // Read data
);
    logic [2:0] wait_reg;
    logic [2:0] wait_next;
    logic ack_next;
    logic [15:0] rdata_next;

    function automatic logic [15:0] mem_word(input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ 16'h3c96;
    endfunction

    always_comb begin
        wait_next = wait_reg;
        ack_next = 1'b0;
        // Data not being returned keeps toggling so a stale sample shows up
        rdata_next = ~rdata_out;
        if (ack_out) begin
            wait_next = 3'h0;
        end else if (bus_req_in) begin
            if (wait_reg >= wait_in) begin
                ack_next = 1'b1;
                rdata_next = mem_word(bus_addr_in);
            end else begin
                wait_next = wait_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_reg <= 3'h0;
            ack_out <= 1'b0;
            rdata_out <= 16'h0000;
        end else begin
            wait_reg <= wait_next;
            ack_out <= ack_next;
            rdata_out <= rdata_next;
        end
    end
endmodule // oamu_bus_model

// File: bench/tb.sv
`timescale 1ns/1ns
module tb;
    localparam int DLY = 1;
    logic clk;
    logic rst_n;
    logic req_valid;
    oamu_pkg::oamu_req_t req;
    logic req_ready;
    logic res_valid;
    oamu_pkg::oamu_res_t res;
    logic bus_req;
    logic [15:0] bus_addr;
    logic bus_byte;
    logic bus_ack;
    logic [15:0] bus_rdata;
    oamu_pkg::oamu_wr_t rf_wr;
    logic rf_busy;
    logic [2:0] bus_wait;
    logic [15:0] regs [8];
    logic [15:0] seed;
    oamu_pkg::oamu_res_t exp_q [$];
    int n_mismatch;
    int check_count;
    int n_reads;
    int n_byte_reads;

    oamu_unit u_oamu_unit (.CLOCK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(req_valid), .REQ_IN(req),
        .REQ_READY_OUT(req_ready), .RES_VALID_OUT(res_valid), .RES_OUT(res), .BUS_REQ_OUT(bus_req),
        .BUS_ADDR_OUT(bus_addr), .BUS_BYTE_OUT(bus_byte), .BUS_ACK_IN(bus_ack), .BUS_RDATA_IN(bus_rdata),
        .RF_WR_IN(rf_wr), .RF_WR_BUSY_OUT(rf_busy));
    oamu_bus_model u_oamu_bus_model (.clk_in(clk), .rst_n_in(rst_n), .bus_req_in(bus_req),
        .bus_addr_in(bus_addr), .wait_in(bus_wait), .ack_out(bus_ack), .rdata_out(bus_rdata));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [15:0] mem_word(input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ 16'h3c96;
    endfunction

    task automatic compare(input logic [36:0] got, input logic [36:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address is left out for register operands, register number for memory ones
    always @(posedge clk) begin
        logic [36:0] m;
        if (res_valid === 1'b1) begin
            m = exp_q[0].unsupported ? 37'h1 : exp_q[0].in_reg ? ~(37'hffff << 17) : ~(37'h7 << 33);
            compare(res & m, exp_q.pop_front() & m);
        end
        if (bus_req === 1'b1 && bus_ack === 1'b1) n_reads++;
        if (bus_req === 1'b1 && bus_ack === 1'b1 && bus_byte === 1'b1) n_byte_reads++;
    end

    task automatic load_regs();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            if (i > 0) compare(37'(rf_busy), 37'h0);
            #DLY;
            seed = lfsr_next(seed);
            regs[i] = seed;
            rf_wr = '{wr_en: 1'b1, wr_idx: 3'(i), wr_data: seed};
        end
        @(posedge clk);
        #DLY;
        rf_wr.wr_en = 1'b0;
    endtask

    task automatic run_op(input logic [2:0] mode, input logic [2:0] r, input logic b);
        oamu_pkg::oamu_res_t e;
        logic [15:0] st;
        logic [15:0] ea;
        logic [15:0] w;
        int nr;
        int n;
        e = '0;
        e.reg_num = r;
        st = (b && r < oamu_pkg::SP_IDX) ? oamu_pkg::STEP_BYTE : oamu_pkg::STEP_WORD;
        nr = 1;
        ea = regs[r];
        case (mode)
            3'h0: begin
                e.in_reg = 1'b1;
                nr = 0;
                e.data = b ? (regs[r] & oamu_pkg::LOW_BYTE_MASK) : regs[r];
            end
            3'h2: regs[r] = regs[r] + st;
            3'h3: begin
                ea = mem_word(regs[r]);
                regs[r] = regs[r] + 16'h0002;
                nr = 2;
            end
            3'h4: begin
                regs[r] = regs[r] - st;
                ea = regs[r];
            end
            3'h5: begin
                regs[r] = regs[r] - 16'h0002;
                ea = mem_word(regs[r]);
                nr = 2;
            end
            3'h6: begin
                ea = mem_word(regs[7]);
                regs[7] = regs[7] + 16'h0002;
                ea = ea + regs[r];
                nr = 2;
            end
            3'h7: begin
                e.unsupported = 1'b1;
                nr = 0;
            end
            default: ;
        endcase
        if (!e.in_reg && !e.unsupported) begin
            w = mem_word(ea);
            e.addr = ea;
            e.data = b ? {8'h00, w[7:0]} : w;
        end
        exp_q.push_back(e);
        @(posedge clk);
        #DLY;
        n_reads = 0;
        n_byte_reads = 0;
        seed = lfsr_next(seed);
        bus_wait = seed[2:0];
        req_valid = 1'b1;
        req = '{spec: {mode, r}, byte_op: b};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        #DLY;
        req_valid = 1'b0;
        // An execute write that collides with the pre-decrement update must be refused
        rf_wr = '{wr_en: (mode[2:1] == 2'h2), wr_idx: r, wr_data: ~regs[r]};
        @(posedge clk);
        compare(37'(rf_busy), 37'(mode[2:1] == 2'h2));
        #DLY;
        rf_wr.wr_en = 1'b0;
        n = 1;
        do begin
            @(posedge clk);
            n++;
        end while (res_valid !== 1'b1 && n < 200);
        if (n >= 200) n_mismatch++;
        compare(37'(n_reads), 37'(nr));
        compare(37'(n_byte_reads), 37'(b && nr > 0));
    endtask

    task automatic op_and_check(input logic [2:0] mode, input logic [2:0] r, input logic b);
        run_op(mode, r, b);
        run_op(3'h0, r, 1'b0);
        if (mode == 3'h6) run_op(3'h0, 3'h7, 1'b0);
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        seed = 16'h4dfa;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        rf_wr = '0;
        bus_wait = 3'h0;
        n_mismatch = 0;
        check_count = 0;
        n_reads = 0;
        n_byte_reads = 0;
        repeat (6) @(posedge clk);
        compare(37'({req_ready, res_valid, bus_req}), 37'h4);
        #DLY;
        rst_n = 1'b1;
        load_regs();
        for (int m = 0; m < 8; m++) begin
            for (int r = 0; r < 8; r++) begin
                op_and_check(3'(m), 3'(r), 1'b0);
                op_and_check(3'(m), 3'(r), 1'b1);
            end
        end
        load_regs();
        for (int k = 0; k < 60; k++) begin
            seed = lfsr_next(seed);
            op_and_check(seed[6:4], seed[2:0], seed[8]);
        end
        print_verdict();
    end
endmodule // tb
